// [tac_cfg.sv]
// thermal alert configuration register, alarm flags and open-drain alert pin
// assumes the bus engine pulses cfg_wr for a host write to this register and
// honours the lock outputs when writing the limit registers
`timescale 1ns/1ps
module tac_cfg (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic cfg_wr,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   input wire logic sample_valid,
   input wire logic [12:0] temp_sample,
   input wire logic [15:0] upper_limit,
   input wire logic [15:0] lower_limit,
   input wire logic [15:0] crit_limit,
   output logic window_lock,
   output logic crit_lock,
   output logic sensor_shutdown,
   output logic above_window,
   output logic below_window,
   output logic above_crit,
   output logic event_out,
   output logic event_oe
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic mode;
      logic pol;
      logic crit_only;
      logic en;
      logic wlock;
      logic clock;
      logic shdn;
      logic [1:0] hyst;
      logic above;
      logic below;
      logic crit;
      logic latch;
      logic status;
      logic pin_oe;
      logic pin_out;
      logic [15:0] rdata;
   } tac_state_t;

   tac_state_t s_q;
   tac_state_t s_d;

   logic signed [14:0] t_s;
   logic signed [14:0] up_s;
   logic signed [14:0] lo_s;
   logic signed [14:0] cr_s;
   logic signed [14:0] h_s;
   logic unlocked;
   logic cond_q;
   logic cond_d;
   logic new_event;
   logic clr;

   // ------------------------------------------------------------
   // operand scaling: limits carry 0.25 degree steps, sample 1/16
   // ------------------------------------------------------------
   // limit bits 1:0 forced to zero so both sides share the 1/16 grid
   // two spare sign bits leave headroom for the hysteresis subtraction
   assign t_s = {{2{temp_sample[12]}}, temp_sample};
   assign up_s = {{2{upper_limit[12]}}, upper_limit[12:2], 2'b00};
   assign lo_s = {{2{lower_limit[12]}}, lower_limit[12:2], 2'b00};
   assign cr_s = {{2{crit_limit[12]}}, crit_limit[12:2], 2'b00};

   // hysteresis amount follows the selected code
   always_comb begin
      case (s_q.hyst)
         2'b01: h_s = tac_pkg::HYST_1P5;
         2'b10: h_s = tac_pkg::HYST_3;
         2'b11: h_s = tac_pkg::HYST_6;
         default: h_s = tac_pkg::HYST_NONE;
      endcase
   end

   assign unlocked = !(s_q.wlock || s_q.clock);
   assign cond_q = s_q.crit_only ? s_q.crit : (s_q.above || s_q.below || s_q.crit);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      clr = 1'b0;
      // lock state before this write decides; new locks bite from next write
      if (cfg_wr) begin
         if (unlocked) begin
            s_d.mode = cfg_wdata[tac_pkg::BIT_MODE];
            s_d.pol = cfg_wdata[tac_pkg::BIT_POL];
            s_d.en = cfg_wdata[tac_pkg::BIT_EN];
            s_d.hyst = cfg_wdata[tac_pkg::BIT_HYST_HI:tac_pkg::BIT_HYST_LO];
         end
         if (!s_q.wlock) begin
            s_d.crit_only = cfg_wdata[tac_pkg::BIT_CRIT_ONLY];
         end
         // locks only ever set; zeros written are ignored
         s_d.wlock = s_q.wlock | cfg_wdata[tac_pkg::BIT_WLOCK];
         s_d.clock = s_q.clock | cfg_wdata[tac_pkg::BIT_CLOCK];
         if (!cfg_wdata[tac_pkg::BIT_SHDN]) begin
            s_d.shdn = 1'b0;
         end else if (unlocked) begin
            s_d.shdn = 1'b1;
         end
         clr = cfg_wdata[tac_pkg::BIT_CLEAR] && s_q.mode;
      end
      // shutdown freezes the flags: no sample is taken; only a write can still make an event
      if (sample_valid && !s_q.shdn) begin
         s_d.above = s_q.above ? (t_s > up_s - h_s) : (t_s > up_s);
         s_d.below = s_q.below ? (t_s < lo_s) : (t_s < lo_s - h_s);
         s_d.crit = s_q.crit ? (t_s > cr_s - h_s) : (t_s > cr_s);
      end
      cond_d = s_d.crit_only ? s_d.crit : (s_d.above || s_d.below || s_d.crit);
      new_event = cond_d && !cond_q;
      // a fresh event in the clearing cycle still latches
      if (!s_d.mode) begin
         s_d.latch = 1'b0;
      end else begin
         s_d.latch = new_event || (s_q.latch && !clr);
      end
      s_d.status = s_d.mode ? s_d.latch : cond_d;
      // open drain: active low pulls when asserted, active high pulls when idle
      s_d.pin_oe = s_d.en && (s_d.status ^ s_d.pol);
      s_d.pin_out = 1'b0;
      // status write data is never looked at; clear and reserved read zero
      s_d.rdata = tac_pkg::CFG_RESET;
      s_d.rdata[tac_pkg::BIT_MODE] = s_d.mode;
      s_d.rdata[tac_pkg::BIT_POL] = s_d.pol;
      s_d.rdata[tac_pkg::BIT_CRIT_ONLY] = s_d.crit_only;
      s_d.rdata[tac_pkg::BIT_EN] = s_d.en;
      s_d.rdata[tac_pkg::BIT_STATUS] = s_d.status;
      s_d.rdata[tac_pkg::BIT_CLEAR] = 1'b0;
      s_d.rdata[tac_pkg::BIT_WLOCK] = s_d.wlock;
      s_d.rdata[tac_pkg::BIT_CLOCK] = s_d.clock;
      s_d.rdata[tac_pkg::BIT_SHDN] = s_d.shdn;
      s_d.rdata[tac_pkg::BIT_HYST_HI:tac_pkg::BIT_HYST_LO] = s_d.hyst;
   end

   // ------------------------------------------------------------
   // registers; power-on reset clears everything
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cfg_rdata = s_q.rdata;
   assign window_lock = s_q.wlock;
   assign crit_lock = s_q.clock;
   assign sensor_shutdown = s_q.shdn;
   assign above_window = s_q.above;
   assign below_window = s_q.below;
   assign above_crit = s_q.crit;
   assign event_out = s_q.pin_out;
   assign event_oe = s_q.pin_oe;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   property p_mode_locked;
      (window_lock || crit_lock) |=> $stable(cfg_rdata[0]) && $stable(cfg_rdata[1]) && $stable(cfg_rdata[3]);
   endproperty
   a_mode_locked: assert property (p_mode_locked) else $error("locked field changed");

   property p_crit_only_locked;
      window_lock |=> $stable(cfg_rdata[2]);
   endproperty
   a_crit_only_locked: assert property (p_crit_only_locked) else $error("critical-only changed under lock");

   property p_lock_sticky;
      window_lock |=> window_lock [*8];
   endproperty
   a_lock_sticky: assert property (p_lock_sticky) else $error("window lock dropped");

   property p_lock_single;
      cfg_wr && cfg_wdata[7] |=> crit_lock && cfg_rdata[7];
   endproperty
   a_lock_single: assert property (p_lock_single) else $error("critical lock not set by one write");

   property p_clear_zero;
      cfg_rdata[15:11] == 5'h00 && cfg_rdata[5] == 1'b0;
   endproperty
   a_clear_zero: assert property (p_clear_zero) else $error("clear or reserved bits read nonzero");

   property p_shdn_refused;
      (window_lock || crit_lock) && !sensor_shutdown |=> !sensor_shutdown;
   endproperty
   a_shdn_refused: assert property (p_shdn_refused) else $error("shutdown set while locked");

   property p_shdn_clear;
      cfg_wr && !cfg_wdata[8] |=> !sensor_shutdown;
   endproperty
   a_shdn_clear: assert property (p_shdn_clear) else $error("shutdown clear refused");

   property p_shdn_freeze;
      sensor_shutdown |=> $stable({above_window, below_window, above_crit});
   endproperty
   a_shdn_freeze: assert property (p_shdn_freeze) else $error("flags moved in shutdown");

   property p_comparator_status;
      !cfg_rdata[0] |-> cfg_rdata[4] == (cfg_rdata[2] ? above_crit : (above_window || below_window || above_crit));
   endproperty
   a_comparator_status: assert property (p_comparator_status) else $error("comparator status wrong");

   property p_clear_latch;
      cfg_rdata[0] && cfg_wr && cfg_wdata[5] && cfg_wdata[0] && cfg_wdata[2] == cfg_rdata[2]
         && !sample_valid |=> !cfg_rdata[4];
   endproperty
   a_clear_latch: assert property (p_clear_latch) else $error("clear did not drop latched alert");

   property p_pin_gate;
      !cfg_rdata[3] |-> !event_oe;
   endproperty
   a_pin_gate: assert property (p_pin_gate) else $error("pin driven while disabled");

   property p_pin_level;
      cfg_rdata[3] |-> event_oe == (cfg_rdata[4] ^ cfg_rdata[1]) && !event_out;
   endproperty
   a_pin_level: assert property (p_pin_level) else $error("pin level does not match polarity");

   // ------------------------------------------------------------
   // write acceptance and event holding
   // ------------------------------------------------------------
   property p_unlocked_write;
      cfg_wr && !window_lock && !crit_lock |=> cfg_rdata[0] == $past(cfg_wdata[0])
         && cfg_rdata[1] == $past(cfg_wdata[1]) && cfg_rdata[3] == $past(cfg_wdata[3]);
   endproperty
   a_unlocked_write: assert property (p_unlocked_write) else $error("unlocked write not taken");

   property p_hyst_write;
      cfg_wr && !window_lock && !crit_lock |=> cfg_rdata[10:9] == $past(cfg_wdata[10:9]);
   endproperty
   a_hyst_write: assert property (p_hyst_write) else $error("hysteresis write not taken");

   property p_wlock_single;
      cfg_wr && cfg_wdata[6] |=> window_lock && cfg_rdata[6];
   endproperty
   a_wlock_single: assert property (p_wlock_single) else $error("window lock not set by one write");

   property p_crit_lock_sticky;
      crit_lock |=> crit_lock;
   endproperty
   a_crit_lock_sticky: assert property (p_crit_lock_sticky) else $error("critical lock dropped");

   // mode and critical-only are frozen here, so only a sample could move status
   property p_status_write;
      window_lock && !cfg_rdata[0] && cfg_wr && !sample_valid |=> $stable(cfg_rdata[4]);
   endproperty
   a_status_write: assert property (p_status_write) else $error("status moved by a write");

   property p_latch_hold;
      cfg_rdata[0] && cfg_rdata[4] && !cfg_wr |=> cfg_rdata[4];
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched alert dropped without clear");

   property p_shdn_no_event;
      sensor_shutdown && !cfg_wr |=> $stable(cfg_rdata[4]);
   endproperty
   a_shdn_no_event: assert property (p_shdn_no_event) else $error("event made in shutdown");

   // ------------------------------------------------------------
   // trip points redone from the pins, not from the datapath
   // ------------------------------------------------------------
   property p_above_set;
      sample_valid && !sensor_shutdown && !above_window
         && $signed(temp_sample) > $signed({upper_limit[12:2], 2'b00}) |=> above_window;
   endproperty
   a_above_set: assert property (p_above_set) else $error("above flag not set past upper limit");

   property p_above_clear;
      above_window && sample_valid && !sensor_shutdown && cfg_rdata[10:9] == 2'h0
         && $signed(temp_sample) <= $signed({upper_limit[12:2], 2'b00}) |=> !above_window;
   endproperty
   a_above_clear: assert property (p_above_clear) else $error("above flag held without hysteresis");

   // the widest hysteresis setting sets the flag whatever code is chosen
   property p_below_set;
      sample_valid && !sensor_shutdown && !below_window
         && $signed(temp_sample) < $signed({lower_limit[12:2], 2'b00}) - tac_pkg::HYST_6 |=> below_window;
   endproperty
   a_below_set: assert property (p_below_set) else $error("below flag not set under lower limit");

   property p_crit_set;
      sample_valid && !sensor_shutdown && !above_crit
         && $signed(temp_sample) > $signed({crit_limit[12:2], 2'b00}) |=> above_crit;
   endproperty
   a_crit_set: assert property (p_crit_set) else $error("critical flag not set past limit");
endmodule

// [tac_host_model.sv]
// host controller model: issues register writes and temperature samples
// assumes the bus engine turns a host write into one cfg_wr pulse
`timescale 1ns/1ps
module tac_host_model (
   input wire logic core_clk,
   output logic cfg_wr,
   output logic [15:0] cfg_wdata,
   output logic sample_valid,
   output logic [12:0] temp_sample
);
   // ----------------------------------------
   // idle state
   // ----------------------------------------
   initial begin
      cfg_wr = 1'b0;
      cfg_wdata = 16'h0000;
      sample_valid = 1'b0;
      temp_sample = 13'h0000;
   end
   // released data shows inverse so stale values cannot pass
   task automatic wr(input logic [15:0] d);
      @(posedge core_clk);
      #2;
      cfg_wr = 1'b1;
      cfg_wdata = d;
      @(posedge core_clk);
      #2;
      cfg_wr = 1'b0;
      cfg_wdata = ~d;
   endtask
   // one conversion pulse
   task automatic smp(input logic [12:0] t);
      @(posedge core_clk);
      #2;
      sample_valid = 1'b1;
      temp_sample = t;
      @(posedge core_clk);
      #2;
      sample_valid = 1'b0;
      temp_sample = ~t;
   endtask
endmodule

// [tac_pkg.sv]
// constants for the thermal alert configuration register block
// assumes a single core clock domain and a bus engine that decodes the pointer
package tac_pkg;
   // ------------------------------------------------------------
   // configuration register layout
   // ------------------------------------------------------------
   localparam int unsigned CFG_W = 16;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam int unsigned BIT_MODE = 0;
   localparam int unsigned BIT_POL = 1;
   localparam int unsigned BIT_CRIT_ONLY = 2;
   localparam int unsigned BIT_EN = 3;
   localparam int unsigned BIT_STATUS = 4;
   localparam int unsigned BIT_CLEAR = 5;
   localparam int unsigned BIT_WLOCK = 6;
   localparam int unsigned BIT_CLOCK = 7;
   localparam int unsigned BIT_SHDN = 8;
   localparam int unsigned BIT_HYST_LO = 9;
   localparam int unsigned BIT_HYST_HI = 10;
   // ------------------------------------------------------------
   // temperature arithmetic, in units of 1/16 degree
   // ------------------------------------------------------------
   localparam int unsigned TW = 15;
   localparam logic signed [14:0] HYST_NONE = 15'sh0000;
   localparam logic signed [14:0] HYST_1P5 = 15'sh0018;
   localparam logic signed [14:0] HYST_3 = 15'sh0030;
   localparam logic signed [14:0] HYST_6 = 15'sh0060;
endpackage

// [tb_thermal_alert_config_register.sv]
// testbench for the configuration register and alert pin
// assumes limits are fixed: window 0x0100..0x0500, critical 0x0800
`timescale 1ns/1ps
module tb_thermal_alert_config_register;
   logic core_clk;
   logic rst_n;
   logic cfg_wr;
   logic [15:0] cfg_wdata;
   logic [15:0] cfg_rdata;
   logic sample_valid;
   logic [12:0] temp_sample;
   logic [15:0] upper_limit = 16'h0500;
   logic [15:0] lower_limit = 16'h0100;
   logic [15:0] crit_limit = 16'h0800;
   logic window_lock, crit_lock, sensor_shutdown, above_window, below_window, above_crit, event_out, event_oe;
   int fail_count = 0;
   int checks = 0;
   int cycles = 0;
   tac_host_model host (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .sample_valid(sample_valid), .temp_sample(temp_sample));
   tac_cfg DUT (.core_clk(core_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .sample_valid(sample_valid), .temp_sample(temp_sample),
      .upper_limit(upper_limit), .lower_limit(lower_limit), .crit_limit(crit_limit),
      .window_lock(window_lock), .crit_lock(crit_lock), .sensor_shutdown(sensor_shutdown),
      .above_window(above_window), .below_window(below_window), .above_crit(above_crit),
      .event_out(event_out), .event_oe(event_oe));
   // ----------------------------------------
   // clock, timeout and reporting
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // whole run needs about 110 cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic results();
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic do_reset();
      #2;
      rst_n = 1'b0;
      repeat (12) @(posedge core_clk);
      #2;
      rst_n = 1'b1;
   endtask
   // write then compare the read value one cycle later
   task automatic wc(input logic [15:0] d, input logic [15:0] e);
      host.wr(d);
      chk(cfg_rdata, e);
   endtask
   task automatic sc(input logic [12:0] t, input logic [15:0] e);
      host.smp(t);
      chk(cfg_rdata, e);
   endtask
   // ----------------------------------------
   // test sequence
   // ----------------------------------------
   initial begin
      rst_n = 1'b0;
      do_reset();
      chk(cfg_rdata, 16'h0000);
      chk(event_oe, 1'b0);
      wc(16'h000B, 16'h000B);
      chk(event_oe, 1'b1);
      sc(13'h0510, 16'h001B);
      chk(event_oe, 1'b0);
      sc(13'h0300, 16'h001B);
      wc(16'h002B, 16'h000B);
      wc(16'h000A, 16'h000A);
      sc(13'h0510, 16'h001A);
      wc(16'h002A, 16'h001A);
      wc(16'h000A, 16'h001A);
      sc(13'h0300, 16'h000A);
      wc(16'h001A, 16'h000A);
      wc(16'h0004, 16'h0004);
      sc(13'h0510, 16'h0004);
      chk(above_window, 1'b1);
      sc(13'h0810, 16'h0014);
      chk(above_crit, 1'b1);
      chk(event_oe, 1'b0);
      wc(16'h000C, 16'h001C);
      chk(event_out, 1'b0);
      chk(event_oe, 1'b1);
      wc(16'h0608, 16'h0618);
      sc(13'h04B0, 16'h0618);
      chk(above_window, 1'b1);
      sc(13'h04A0, 16'h0608);
      chk(above_window, 1'b0);
      // below flag: sets under lower minus 6 degrees, clears at lower
      sc(13'h00B0, 16'h0608);
      chk(below_window, 1'b0);
      sc(13'h0090, 16'h0618);
      chk(below_window, 1'b1);
      sc(13'h00F0, 16'h0618);
      chk(below_window, 1'b1);
      sc(13'h0100, 16'h0608);
      chk(below_window, 1'b0);
      // every hysteresis code, ending on none
      for (int i = 3; i >= 0; i--) begin
         wc(16'(i << 9), 16'(i << 9));
      end
      wc(16'h0100, 16'h0100);
      chk(sensor_shutdown, 1'b1);
      sc(13'h0510, 16'h0100);
      chk(above_window, 1'b0);
      wc(16'h0000, 16'h0000);
      // fields were programmed above, before the lock write
      wc(16'h0040, 16'h0040);
      chk(window_lock, 1'b1);
      wc(16'h071F, 16'h0040);
      wc(16'h0080, 16'h00C0);
      chk(crit_lock, 1'b1);
      do_reset();
      chk(cfg_rdata, 16'h0000);
      wc(16'h0100, 16'h0100);
      wc(16'h0180, 16'h0180);
      wc(16'h0080, 16'h0080);
      wc(16'h0180, 16'h0080);
      wc(16'h0084, 16'h0084);
      wc(16'hF800, 16'h0080);
      wc(16'h0100, 16'h0080);
      do_reset();
      chk(cfg_rdata, 16'h0000);
      results();
   end
endmodule
